// [pllc_regs.sv]
// control and status register block for a frequency-synthesising loop
//
// Behaviour
// - status bit 31 shows lock, reads zero after reset, read-only
// - bit 8 routes undivided reference to output; oscillator keeps running
// - bits 5:0 divide reference, reset to one; zero is undefined
// - power bit 5 powers down the oscillator, resets to one
// - power bit 3 powers down output dividers, resets to one
// - power bit 2 powers down the modulator, resets to one
// - power bit 0 is main loop power-down, set after reset
// - feedback divisor 12-bit integer, resets zero; software uses 16 to 320
// - output dividers at bits 18:16 and 14:12, each 1 to 7, reset 7
// - two identical instances sit at separate base addresses
// - output equals reference over ref div times feedback over out divs
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module pllc_regs
#(
    parameter int SETTLE_CNT = pllc_pkg::SETTLE_CYCLES
)
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // axi4-lite slave
    input  wire logic [3:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [3:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // analogue side
    input  wire logic        i_ref_tick,
    input  wire logic        i_vco_tick,
    output logic [5:0]       o_ref_div,
    output logic [11:0]      o_fb_div,
    output logic             o_vco_powerdown,
    output logic             o_output_divider_off,
    output logic             o_sigma_delta_off,
    output logic             o_main_power_off,
    output logic             o_pass_through,
    output logic             o_out_tick,
    output logic             o_locked
);
    import pllc_pkg::*;

    localparam int CW = $clog2(SETTLE_CNT + 1);

    typedef struct packed
    {
        logic          aw_full;
        logic [3:0]    aw_addr;
        logic          w_full;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [1:0]    rresp;
        logic [31:0]   rdata;
        logic          pass;
        logic [5:0]    ref_div;
        logic [11:0]   fb_div;
        logic          vco_off;
        logic          odiv_off;
        logic          sd_off;
        logic          main_off;
        logic [2:0]    div1;
        logic [2:0]    div2;
        logic [CW-1:0] settle;
        logic          lock;
        logic          out_tick;
    } pllc_state_t;

    pllc_state_t st;
    pllc_state_t next_st;

    // ========================================================
    // output divider chain
    pllc_div_if div_bus ();

    assign div_bus.run  = !st.odiv_off && !st.vco_off && !st.main_off;
    assign div_bus.div1 = st.div1;
    assign div_bus.div2 = st.div2;

    pllc_out_div u_out_div
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_en      (i_vco_tick),
        .dv        (div_bus.div)
    );

    // ========================================================
    // bus write merge helper
    function automatic logic [31:0] merge
    (
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [31:0] cur_cs;
    logic [31:0] cur_pwr;
    logic [31:0] cur_fb;
    logic [31:0] cur_od;

    always_comb
    begin
        cur_cs  = '0;
        cur_pwr = '0;
        cur_fb  = '0;
        cur_od  = '0;
        cur_cs[POS_LOCK]              = st.lock;
        cur_cs[POS_PASS]              = st.pass;
        cur_cs[POS_REF_MSB:0]         = st.ref_div;
        cur_pwr[POS_VCO_OFF]          = st.vco_off;
        cur_pwr[POS_ODIV_OFF]         = st.odiv_off;
        cur_pwr[POS_SD_OFF]           = st.sd_off;
        cur_pwr[POS_MAIN_OFF]         = st.main_off;
        cur_fb[POS_FB_MSB:0]          = st.fb_div;
        cur_od[POS_DIV1_LSB +: 3]     = st.div1;
        cur_od[POS_DIV2_LSB +: 3]     = st.div2;
    end

    // ========================================================
    // next state
    logic        do_wr;
    logic [31:0] wv;

    always_comb
    begin
        next_st          = st;
        next_st.out_tick = 1'b0;
        wv               = '0;
        // address and data taken in either order
        if (i_awvalid && o_awready)
        begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
            next_st.w_full = 1'b1;
            next_st.w_data = i_wdata;
            next_st.w_strb = i_wstrb;
        end
        do_wr = st.aw_full && st.w_full && !st.bvalid;
        if (do_wr)
        begin
            next_st.aw_full = 1'b0;
            next_st.w_full  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_OKAY;
            // only the offset arrives; each instance sits at its own base
            if (st.aw_addr == OFF_CTRL_STATUS)
            begin
                wv = merge(cur_cs, st.w_data, st.w_strb);
                next_st.pass    = wv[POS_PASS];
                next_st.ref_div = wv[POS_REF_MSB:0];
            end
            else if (st.aw_addr == OFF_POWER)
            begin
                wv = merge(cur_pwr, st.w_data, st.w_strb);
                next_st.vco_off  = wv[POS_VCO_OFF];
                next_st.odiv_off = wv[POS_ODIV_OFF];
                next_st.sd_off   = wv[POS_SD_OFF];
                next_st.main_off = wv[POS_MAIN_OFF];
            end
            else if (st.aw_addr == OFF_FEEDBACK)
            begin
                wv = merge(cur_fb, st.w_data, st.w_strb);
                next_st.fb_div = wv[POS_FB_MSB:0];
            end
            else if (st.aw_addr == OFF_OUT_DIV)
            begin
                wv = merge(cur_od, st.w_data, st.w_strb);
                next_st.div1 = wv[POS_DIV1_LSB +: 3];
                next_st.div2 = wv[POS_DIV2_LSB +: 3];
            end
            else
            begin
                next_st.bresp = RESP_SLVERR;
            end
        end
        if (st.bvalid && i_bready)
        begin
            next_st.bvalid = 1'b0;
        end
        // reads answer one cycle after the address is taken
        if (i_arvalid && o_arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            if (i_araddr == OFF_CTRL_STATUS)
            begin
                next_st.rdata = cur_cs;
            end
            else if (i_araddr == OFF_POWER)
            begin
                next_st.rdata = cur_pwr;
            end
            else if (i_araddr == OFF_FEEDBACK)
            begin
                next_st.rdata = cur_fb;
            end
            else if (i_araddr == OFF_OUT_DIV)
            begin
                next_st.rdata = cur_od;
            end
            else
            begin
                next_st.rdata = '0;
                next_st.rresp = RESP_SLVERR;
            end
        end
        else if (st.rvalid && i_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        // lock model: a settle count of reference ticks while powered
        if (next_st.main_off || next_st.vco_off
            || next_st.ref_div != st.ref_div
            || next_st.fb_div != st.fb_div)
        begin
            next_st.settle = '0;
            next_st.lock   = 1'b0;
        end
        else if (!st.lock && i_ref_tick)
        begin
            if (st.settle == CW'(SETTLE_CNT - 1))
            begin
                next_st.lock = 1'b1;
            end
            else
            begin
                next_st.settle = st.settle + 1'b1;
            end
        end
        // bypass picks reference, else divided oscillator
        next_st.out_tick = st.pass ? i_ref_tick : div_bus.tick;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st          <= '0;
            st.ref_div  <= RST_REF_DIV;
            st.fb_div   <= RST_FB_DIV;
            st.vco_off  <= RST_POWER_OFF;
            st.odiv_off <= RST_POWER_OFF;
            st.sd_off   <= RST_POWER_OFF;
            st.main_off <= RST_POWER_OFF;
            st.div1     <= RST_OUT_DIV;
            st.div2     <= RST_OUT_DIV;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ========================================================
    // outputs
    // one write outstanding: hold both channels until the answer drains
    assign o_awready            = !st.aw_full && !st.bvalid;
    assign o_wready             = !st.w_full && !st.bvalid;
    assign o_bvalid             = st.bvalid;
    assign o_bresp              = st.bresp;
    assign o_arready            = !st.rvalid;
    assign o_rvalid             = st.rvalid;
    assign o_rdata              = st.rdata;
    assign o_rresp              = st.rresp;
    assign o_ref_div            = st.ref_div;
    assign o_fb_div             = st.fb_div;
    assign o_vco_powerdown      = st.vco_off;
    assign o_output_divider_off = st.odiv_off;
    assign o_sigma_delta_off    = st.sd_off;
    assign o_main_power_off     = st.main_off;
    assign o_pass_through       = st.pass;
    assign o_out_tick           = st.out_tick;
    assign o_locked             = st.lock;

    // ========================================================
    // checks
    a_lock_power_drop: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n) (st.main_off || st.vco_off) |-> !st.lock)
        else $error("lock shown while loop powered down");
    a_lock_on_change: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n) ($changed(st.fb_div) || $changed(st.ref_div))
        |-> !st.lock)
        else $error("lock kept across divider change");
    a_lock_bit_read: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (i_arvalid && o_arready && i_araddr == OFF_CTRL_STATUS)
        |=> o_rdata[31] == $past(st.lock))
        else $error("status read does not show lock");
    a_pass_route: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n) (st.pass && i_ref_tick) |=> o_out_tick)
        else $error("reference not routed in pass-through");
    a_ref_wr: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (do_wr && st.aw_addr == OFF_CTRL_STATUS && st.w_strb[0])
        |=> st.ref_div == $past(st.w_data[5:0]))
        else $error("reference divider write lost");
    a_power_wr: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (do_wr && st.aw_addr == OFF_POWER && st.w_strb[0])
        |=> {st.vco_off, st.odiv_off, st.sd_off, st.main_off}
            == {$past(st.w_data[5]), $past(st.w_data[3]),
                $past(st.w_data[2]), $past(st.w_data[0])})
        else $error("power bits write lost");
    a_fb_wr: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (do_wr && st.aw_addr == OFF_FEEDBACK && (&st.w_strb[1:0]))
        |=> st.fb_div == $past(st.w_data[11:0]))
        else $error("feedback divisor write lost");
    a_odiv_wr: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        (do_wr && st.aw_addr == OFF_OUT_DIV && (&st.w_strb[2:1]))
        |=> st.div1 == $past(st.w_data[18:16])
            && st.div2 == $past(st.w_data[14:12]))
        else $error("output divider write lost");
    a_out_gated: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n) (!st.pass && st.odiv_off) |=> ##1 !o_out_tick)
        else $error("output ticks with dividers powered down");

endmodule : pllc_regs

// [pllc_pkg.sv]
// shared constants and types for the loop control register block
package pllc_pkg;

    // ========================================================
    // register map
    localparam logic [3:0]  OFF_CTRL_STATUS = 4'h0;
    localparam logic [3:0]  OFF_POWER       = 4'h4;
    localparam logic [3:0]  OFF_FEEDBACK    = 4'h8;
    localparam logic [3:0]  OFF_OUT_DIV     = 4'hc;

    // ========================================================
    // field positions
    localparam int          POS_LOCK        = 31;
    localparam int          POS_PASS        = 8;
    localparam int          POS_REF_MSB     = 5;
    localparam int          POS_VCO_OFF     = 5;
    localparam int          POS_ODIV_OFF    = 3;
    localparam int          POS_SD_OFF      = 2;
    localparam int          POS_MAIN_OFF    = 0;
    localparam int          POS_FB_MSB      = 11;
    localparam int          POS_DIV1_LSB    = 16;
    localparam int          POS_DIV2_LSB    = 12;

    // ========================================================
    // reset values
    localparam logic [5:0]  RST_REF_DIV     = 6'h01;
    localparam logic [11:0] RST_FB_DIV      = 12'h000;
    localparam logic [2:0]  RST_OUT_DIV     = 3'h7;
    localparam logic        RST_POWER_OFF   = 1'h1;

    // ========================================================
    // timing: loop settling time before lock is reported
    localparam int          SETTLE_NS       = 10000;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;

    // ========================================================
    // bus response codes
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : pllc_pkg

// [pllc_div_if.sv]
// carrier between the register block and the output divider chain
`timescale 1ns/1ps
interface pllc_div_if;
    logic       run;
    logic [2:0] div1;
    logic [2:0] div2;
    logic       tick;

    modport ctrl
    (
        output run,
        output div1,
        output div2,
        input  tick
    );
    modport div
    (
        input  run,
        input  div1,
        input  div2,
        output tick
    );
endinterface : pllc_div_if

// [pllc_out_div.sv]
// two cascaded output dividers, each dividing by 1 to 7
`timescale 1ns/1ps
module pllc_out_div
(
    input  wire logic  i_clk_sys,
    input  wire logic  i_rst_n,
    input  wire logic  i_en,
    pllc_div_if.div    dv
);
    import pllc_pkg::*;

    typedef struct packed
    {
        logic [2:0] cnt1;
        logic [2:0] cnt2;
        logic       tick;
    } pllc_odiv_t;

    pllc_odiv_t st;
    pllc_odiv_t next_st;

    // ========================================================
    // cascade: second stage counts first-stage wraps
    always_comb
    begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (!dv.run)
        begin
            next_st.cnt1 = 3'h0;
            next_st.cnt2 = 3'h0;
        end
        else if (i_en)
        begin
            if (st.cnt1 + 3'h1 >= dv.div1)
            begin
                next_st.cnt1 = 3'h0;
                if (st.cnt2 + 3'h1 >= dv.div2)
                begin
                    next_st.cnt2 = 3'h0;
                    next_st.tick = 1'b1;
                end
                else
                begin
                    next_st.cnt2 = st.cnt2 + 3'h1;
                end
            end
            else
            begin
                next_st.cnt1 = st.cnt1 + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign dv.tick = st.tick;

    // a stopped chain never ticks
    a_div_stop_quiet: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n) !dv.run |=> !dv.tick)
        else $error("output divider ticked while stopped");

endmodule : pllc_out_div

// [pllc_regs_tb_top.sv]
// self-checking bench for the loop control register block
`timescale 1ns/1ps
module pllc_regs_tb_top;
    import pllc_pkg::*;
    localparam int SETTLE = 4;

    logic        i_clk_sys = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic [3:0]  i_awaddr  = 4'h0;
    logic        i_awvalid = 1'b0;
    logic [31:0] i_wdata   = 32'h0;
    logic [3:0]  i_wstrb   = 4'h0;
    logic        i_wvalid  = 1'b0;
    logic        i_bready  = 1'b0;
    logic [3:0]  i_araddr  = 4'h0;
    logic        i_arvalid = 1'b0;
    logic        i_rready  = 1'b0;
    logic        i_ref_tick = 1'b0;
    logic        i_vco_tick = 1'b0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [5:0]  o_ref_div;
    logic [11:0] o_fb_div;
    logic        o_vco_powerdown, o_output_divider_off, o_sigma_delta_off;
    logic        o_main_power_off, o_pass_through, o_out_tick, o_locked;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          out_cnt = 0;
    int          ref_cnt = 0;
    logic [7:0]  tick_cnt = 8'h0;
    logic        ref_en = 1'b0;
    logic        vco_en = 1'b0;
    logic [15:0] lfsr = 16'h002d;
    logic [31:0] shadow [4];

    always #4 i_clk_sys = ~i_clk_sys;

    pllc_regs #(.SETTLE_CNT(SETTLE)) u_dut
    (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready),
        .i_ref_tick(i_ref_tick), .i_vco_tick(i_vco_tick),
        .o_ref_div(o_ref_div), .o_fb_div(o_fb_div),
        .o_vco_powerdown(o_vco_powerdown),
        .o_output_divider_off(o_output_divider_off),
        .o_sigma_delta_off(o_sigma_delta_off),
        .o_main_power_off(o_main_power_off),
        .o_pass_through(o_pass_through), .o_out_tick(o_out_tick),
        .o_locked(o_locked)
    );

    // ========================================================
    // analogue side stand-in: reference every 8 cycles, vco every cycle
    always @(posedge i_clk_sys)
    begin
        tick_cnt   <= tick_cnt + 8'h1;
        i_ref_tick <= ref_en && (tick_cnt[2:0] == 3'h0);
        i_vco_tick <= vco_en;
    end

    // counted mid-cycle so registered outputs are settled
    always @(negedge i_clk_sys)
    begin
        if (o_out_tick === 1'b1) out_cnt++;
        if (i_ref_tick === 1'b1) ref_cnt++;
    end

    // ========================================================
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [31:0] reg_mask(input logic [1:0] i);
        case (i)
            2'd0:    return 32'h0000013f;
            2'd1:    return 32'h0000002d;
            2'd2:    return 32'h00000fff;
            default: return 32'h00077000;
        endcase
    endfunction : reg_mask

    function automatic logic [31:0] pins_exp();
        return {9'h0, shadow[0][8], shadow[0][5:0], shadow[2][11:0],
                shadow[1][5], shadow[1][3], shadow[1][2], shadow[1][0]};
    endfunction : pins_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s %h vs %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // ========================================================
    // axi4-lite master: handshakes judged mid-cycle, acted on at the edge
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic aw_p, w_p, aw_h, w_h, b_h, done;
        int   n;
        aw_p = 1'b1; w_p = 1'b1; done = 1'b0; n = 0; r = 2'h3;
        @(posedge i_clk_sys);
        i_awaddr <= a; i_awvalid <= 1'b1;
        i_wdata <= d; i_wstrb <= s; i_wvalid <= 1'b1; i_bready <= 1'b1;
        while (!done && n < 200)
        begin
            @(negedge i_clk_sys);
            aw_h = aw_p && o_awready;
            w_h  = w_p && o_wready;
            b_h  = !aw_p && !w_p && (o_bvalid === 1'b1);
            if (b_h) r = o_bresp;
            @(posedge i_clk_sys);
            if (aw_h) begin i_awvalid <= 1'b0; aw_p = 1'b0; end
            if (w_h) begin i_wvalid <= 1'b0; w_p = 1'b0; end
            if (b_h) begin i_bready <= 1'b0; done = 1'b1; end
            n++;
        end
        if (!done) chk(32'h0, 32'h1, "write stalled");
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic ar_p, ar_h, r_h, done;
        int   n;
        ar_p = 1'b1; done = 1'b0; n = 0; r = 2'h3; d = 32'hx;
        @(posedge i_clk_sys);
        i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
        while (!done && n < 200)
        begin
            @(negedge i_clk_sys);
            ar_h = ar_p && o_arready;
            r_h  = !ar_p && (o_rvalid === 1'b1);
            if (r_h) begin d = o_rdata; r = o_rresp; end
            @(posedge i_clk_sys);
            if (ar_h) begin i_arvalid <= 1'b0; ar_p = 1'b0; end
            if (r_h) begin i_rready <= 1'b0; done = 1'b1; end
            n++;
        end
        if (!done) chk(32'h0, 32'h1, "read stalled");
    endtask : axi_read

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, 4'hf, r);
        shadow[a[3:2]] = d & reg_mask(a[3:2]);
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        chk(d, e, "read data");
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
    endtask : rd_chk

    // reset values of every register and of every control pin
    task automatic do_reset();
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        shadow = '{32'h00000001, 32'h0000002d, 32'h0, 32'h00077000};
        rd_chk(OFF_CTRL_STATUS, 32'h00000001);
        rd_chk(OFF_POWER, 32'h0000002d);
        rd_chk(OFF_FEEDBACK, 32'h00000000);
        rd_chk(OFF_OUT_DIV, 32'h00077000);
        chk(pins_exp(), {9'h0, o_pass_through, o_ref_div, o_fb_div,
            o_vco_powerdown, o_output_divider_off, o_sigma_delta_off,
            o_main_power_off}, "reset pins");
        $display("test reset done");
    endtask : do_reset

    task automatic wait_lock();
        int n;
        n = 0;
        while (o_locked !== 1'b1 && n < (SETTLE + 3) * 8 + 20)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        chk({31'h0, o_locked}, 32'h1, "lock after settling");
    endtask : wait_lock

    task automatic measure(input int cyc, input int exp);
        int c0, d;
        c0 = out_cnt;
        repeat (cyc) @(posedge i_clk_sys);
        d = out_cnt - c0;
        chk({31'h0, (d >= exp - 1 && d <= exp + 1)}, 32'h1, "output rate");
    endtask : measure

    // ========================================================
    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        logic [31:0] d, e;
        logic [1:0]  r, ix;
        int          c0;
        do_reset();

        // random register traffic, ref divider kept nonzero, fb 16..320
        repeat (24)
        begin
            lfsr = lfsr_next(lfsr);
            ix   = lfsr[1:0];
            d    = {lfsr, lfsr_next(lfsr) ^ 16'h5a5a};
            if (ix == 2'd0 && d[5:0] == 6'h0) d[0] = 1'b1;
            if (ix == 2'd2) d[11:0] = 12'd16 + 12'(lfsr % 16'd305);
            wr({ix, 2'b00}, d);
            rd_chk({ix, 2'b00}, shadow[ix]);
            chk(pins_exp(), {9'h0, o_pass_through, o_ref_div, o_fb_div,
                o_vco_powerdown, o_output_divider_off, o_sigma_delta_off,
                o_main_power_off}, "control pins");
        end
        // lock bit write ignored while loop stays off
        wr(OFF_CTRL_STATUS, 32'h80000005);
        rd_chk(OFF_CTRL_STATUS, 32'h00000005);
        // top of the feedback range, then a single-byte update
        wr(OFF_FEEDBACK, 32'h00000140);
        axi_write(OFF_FEEDBACK, 32'h00000000, 4'h2, r);
        rd_chk(OFF_FEEDBACK, 32'h00000040);
        // unmapped places
        axi_write(4'h2, 32'hffffffff, 4'hf, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
        axi_read(4'h6, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
        chk(d, 32'h0, "unmapped data");
        $display("test random access done");

        do_reset();
        // documented bring-up order
        ref_en <= 1'b1;
        wr(OFF_CTRL_STATUS, 32'h00000001);
        wr(OFF_FEEDBACK, 32'h00000064);
        // a tick on the power-on edge already counts toward settling
        c0 = ref_cnt;
        wr(OFF_POWER, 32'h0000000c);
        chk({31'h0, o_locked}, 32'h0, "lock right after power-up");
        wait_lock();
        chk({31'h0, (ref_cnt - c0 >= SETTLE)}, 32'h1, "settle ticks");
        rd_chk(OFF_CTRL_STATUS, 32'h80000001);
        wr(OFF_OUT_DIV, 32'h00032000);
        wr(OFF_POWER, 32'h00000004);
        vco_en <= 1'b1;
        measure(8, 1);
        measure(120, 20);
        $display("test bring-up done");

        // divider change drops lock until settled again
        wr(OFF_CTRL_STATUS, 32'h00000002);
        chk({31'h0, o_locked}, 32'h0, "lock after ref change");
        wait_lock();
        // pass-through: reference rate reaches the output, vco stays on
        wr(OFF_CTRL_STATUS, 32'h00000102);
        measure(8, 1);
        measure(160, 20);
        chk({31'h0, o_vco_powerdown}, 32'h0, "vco kept running");
        chk({31'h0, o_locked}, 32'h1, "lock kept in bypass");
        wr(OFF_CTRL_STATUS, 32'h00000002);
        measure(8, 1);
        measure(120, 20);
        // main power-down and vco power-down each drop lock
        wr(OFF_POWER, 32'h00000005);
        chk({31'h0, o_locked}, 32'h0, "lock with main off");
        wr(OFF_POWER, 32'h00000004);
        wait_lock();
        wr(OFF_POWER, 32'h00000024);
        chk({31'h0, o_locked}, 32'h0, "lock with vco off");
        $display("test lock and bypass done");
        report_and_stop();
    end
endmodule : pllc_regs_tb_top
